// file: rtl/thl_consts.vh
// Constants for the tag head link command block: offsets, codes and reset values
`ifndef THL_CONSTS_VH
`define THL_CONSTS_VH

// ==========================================================
// Register byte offsets
`define THL_ACT_STATE 8'h00
`define THL_CMD_STATE 8'h04
`define THL_AUTO_MODE 8'h08
`define THL_TAG_STAT 8'h0C
`define THL_BUF0_CTRL 8'h10
`define THL_BUF1_CTRL 8'h14
`define THL_BUF0_STAT 8'h18
`define THL_BUF1_STAT 8'h1C
`define THL_BUF0_DATA 8'h20
`define THL_BUF1_DATA 8'h24
`define THL_MAP0_BASE 8'h40
`define THL_MAP1_BASE 8'h50
`define THL_TP4_BASE 8'h60
`define THL_SUB1 8'h04
`define THL_SUB2 8'h08

// ==========================================================
// Actual link state codes
`define THL_LS_IDLE 3'h0
`define THL_LS_CONNECTING 3'h1
`define THL_LS_FETCHING 3'h2
`define THL_LS_PREFETCH_DONE 3'h3
`define THL_LS_CONNECTED 3'h4
`define THL_LS_ERROR 3'h5

// ==========================================================
// Commanded link state, auto mode and buffer control values
`define THL_CMD_CONNECT 8'h01
`define THL_CMD_DISCONNECT 8'h02
`define THL_CMD_RECONNECT 8'h03
`define THL_CMD_ERROR 8'h04
`define THL_AUTO_NONE 8'h00
`define THL_AUTO_RECONNECT 8'h01
`define THL_AUTO_DISCONNECT 8'h02
`define THL_BC_LOCK 8'h00
`define THL_BC_DIRECT 8'h01
`define THL_BC_PREFETCH 8'h03

// ==========================================================
// Buffer status codes
`define THL_BS_LOCKED 8'h00
`define THL_BS_READY 8'h01
`define THL_BS_BUSY 8'h02
`define THL_BS_DONE 8'h03

// ==========================================================
// Mapping layout, PDO numbers and reset values
`define THL_MAP_STATUS_BIT 31
`define THL_TP4_ENT1 32'h21000208
`define THL_TP4_ENT2 32'h21010208
`define THL_TP4_CNT 8'h02
`define THL_PDO1 3'h1
`define THL_PDO2 3'h2
`define THL_PDO4 3'h4
`define THL_AUTO_RST 8'h00
`define THL_CTRL_RST 8'h00

`endif

// file: rtl/thl_buf_mem.v
// Byte memory holding the data of transfer buffer 0, registered read port
`timescale 1ns/10ps
module thl_buf_mem #(
	parameter AW = 6,
	parameter DW = 8
) (
	input wire mclk, // System clock
	input wire rst_b, // Async reset, active low
	input wire wrEn, // Write strobe
	input wire [AW-1:0] wrAddr, // Write address
	input wire [DW-1:0] wrData, // Write data
	input wire [AW-1:0] rdAddr, // Read address
	output reg [DW-1:0] rdData // Read data, one cycle later
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// ==========================================================
	// Write port
	always @(posedge mclk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Registered read port
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= {DW{1'b0}};
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

// file: rtl/thl_link_cmd.v
// Command interpreter of the read_write_head: link states, mapping, prefetch and PDO events
`timescale 1ns/10ps
`include "thl_consts.vh"

module thl_link_cmd #(
	parameter BUF_AW = 6
) (
	input wire mclk, // System clock, 125 MHz
	input wire rst_b, // Async reset, active low
	input wire [7:0] regAddr, // Register byte address
	input wire [31:0] regWdata, // Register write data
	input wire regWr, // Write strobe
	input wire regRd, // Read strobe
	output wire [31:0] regRdata, // Read data, cycle after strobe
	input wire tagPresent, // A mobile_tag is in the field
	input wire [7:0] tagStatus, // Status byte of the present tag
	output reg tagReq_r, // Tag access request, held until ack or a command write
	output reg tagWe_r, // Access is a write
	output reg [17:0] tagAddr_r, // Tag byte address
	output reg [7:0] tagWdata_r, // Tag write byte
	input wire tagAck, // Tag access done
	input wire [7:0] tagRdata, // Tag read byte, valid with ack
	output reg pdoValid_r, // Transmit PDO pulse
	output reg [2:0] pdoNum_r, // PDO number 1, 2 or 4
	output reg [63:0] pdoData_r // PDO payload
);

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_CONN = 6'h02;
	localparam [5:0] ST_FETCH = 6'h04;
	localparam [5:0] ST_DONE = 6'h08;
	localparam [5:0] ST_LINKED = 6'h10;
	localparam [5:0] ST_ERR = 6'h20;

	reg [5:0] state_r;
	reg [5:0] prevState_r;
	reg [7:0] auto_r;
	reg waitGone_r;
	reg fIdx_r;
	reg [15:0] fOff_r;
	reg [BUF_AW:0] wPtr_r;
	reg [BUF_AW-1:0] rPtr_r;
	reg [15:0] dOff_r;
	reg [7:0] buf0Stat_r;
	reg [7:0] buf1Stat_r;
	reg [15:0] prevStat_r;
	reg [7:0] tagStat_r;
	reg [63:0] pdo2Cap_r;
	reg [2:0] pend_r;
	reg [7:0] tp4Cnt_r;
	reg [31:0] tp4E1_r;
	reg [31:0] tp4E2_r;
	reg [31:0] rdata_r;
	reg rdMem_r;
	reg [2:0] linkCode;
	reg [2:0] sentCode_r;
	reg [31:0] rdMux;
	wire [7:0] memQ;

	// ==========================================================
	// Register decode
	wire wrCmd = regWr & (regAddr == `THL_CMD_STATE);
	wire [7:0] cmd = regWdata[7:0];
	wire wrB0Data = regWr & (regAddr == `THL_BUF0_DATA);
	wire wrB1Data = regWr & (regAddr == `THL_BUF1_DATA);
	wire rdB0Data = regRd & (regAddr == `THL_BUF0_DATA);

	// ==========================================================
	// Per buffer control and mapping registers
	wire [15:0] ctrlW;
	wire [15:0] cntW;
	wire [63:0] prep1W;
	wire [63:0] prep2W;
	wire [63:0] act1W;
	wire [63:0] act2W;
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1) begin : gBuf
			localparam [7:0] CB = (b == 0) ? `THL_BUF0_CTRL : `THL_BUF1_CTRL;
			localparam [7:0] MB = (b == 0) ? `THL_MAP0_BASE : `THL_MAP1_BASE;
			reg [7:0] ctrl_r;
			reg [7:0] cnt_r;
			reg [31:0] prep1_r;
			reg [31:0] prep2_r;
			reg [31:0] act1_r;
			reg [31:0] act2_r;
			wire locked = (ctrl_r == `THL_BC_LOCK);
			// Control writes; mapping changes only while locked
			always @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					ctrl_r <= `THL_CTRL_RST;
					cnt_r <= 8'h00;
					prep1_r <= 32'h0;
					prep2_r <= 32'h0;
					act1_r <= 32'h0;
					act2_r <= 32'h0;
				end else begin
					if (regWr & (regAddr == CB)) begin
						ctrl_r <= regWdata[7:0];
					end
					if (regWr & locked) begin
						if (regAddr == MB + `THL_SUB1) begin
							prep1_r <= regWdata;
						end
						if (regAddr == MB + `THL_SUB2) begin
							prep2_r <= regWdata;
						end
						if (regAddr == MB) begin
							if (regWdata == 32'h0) begin
								cnt_r <= 8'h00;
								prep1_r <= 32'h0;
								prep2_r <= 32'h0;
								act1_r <= 32'h0;
								act2_r <= 32'h0;
							end else begin
								cnt_r <= regWdata[7:0];
								act1_r <= prep1_r;
								act2_r <= prep2_r;
							end
						end
					end
				end
			end
			assign ctrlW[b*8 +: 8] = ctrl_r;
			assign cntW[b*8 +: 8] = cnt_r;
			assign prep1W[b*32 +: 32] = prep1_r;
			assign prep2W[b*32 +: 32] = prep2_r;
			assign act1W[b*32 +: 32] = act1_r;
			assign act2W[b*32 +: 32] = act2_r;
		end
	endgenerate

	// ==========================================================
	// Prefetch walk over buffer 0 entries
	wire inFetch = (state_r == ST_FETCH);
	wire [31:0] curEnt = fIdx_r ? act2W[31:0] : act1W[31:0];
	wire curEmpty = (curEnt[15:0] == fOff_r);
	wire curIsStat = curEnt[`THL_MAP_STATUS_BIT];
	wire gotByte = inFetch & ~curEmpty & ~wrCmd & (curIsStat | (tagReq_r & tagAck));
	wire [7:0] gotData = curIsStat ? tagStatus : tagRdata;
	wire memWe = gotByte & ~wPtr_r[BUF_AW];
	wire fetchEnd = inFetch & curEmpty & fIdx_r & ~wrCmd;
	wire [17:0] fetchAddr = {curEnt[31:16], 2'b00} + {2'b00, fOff_r};
	wire doFetch = (ctrlW[7:0] == `THL_BC_PREFETCH) & (cntW[7:0] != 8'h00);
	wire tagArrive = (state_r == ST_CONN) & tagPresent & ~waitGone_r & ~wrCmd;

	// Direct exchange target on buffer 1
	wire [31:0] b1Ent = (act1W[63:32] != 32'h0) ? act1W[63:32] : act2W[63:32];
	wire b1Direct = (ctrlW[15:8] == `THL_BC_DIRECT) & (cntW[15:8] != 8'h00);
	wire dirGo = wrB1Data & b1Direct & (state_r == ST_LINKED) & ~tagReq_r &
		(dOff_r != b1Ent[15:0]);

	// PDO event sources
	wire tp4Ok = (tp4Cnt_r == `THL_TP4_CNT) & (tp4E1_r == `THL_TP4_ENT1) &
		(tp4E2_r == `THL_TP4_ENT2);
	wire [2:0] setPend;
	wire [2:0] sentPend;
	assign setPend[0] = (state_r != prevState_r);
	assign setPend[1] = fetchEnd | (tagArrive & ~doFetch);
	assign setPend[2] = tp4Ok & ({buf1Stat_r, buf0Stat_r} != prevStat_r);
	assign sentPend[0] = pend_r[0];
	assign sentPend[1] = pend_r[1] & ~pend_r[0];
	assign sentPend[2] = pend_r[2] & ~pend_r[0] & ~pend_r[1];

	thl_buf_mem #(
		.AW(BUF_AW),
		.DW(8)
	) uMem (
		.mclk(mclk),
		.rst_b(rst_b),
		.wrEn(memWe),
		.wrAddr(wPtr_r[BUF_AW-1:0]),
		.wrData(gotData),
		.rdAddr(rPtr_r),
		.rdData(memQ)
	);

	// ==========================================================
	// Link state machine, tag accesses and buffer status
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			auto_r <= `THL_AUTO_RST;
			waitGone_r <= 1'b0;
			fIdx_r <= 1'b0;
			fOff_r <= 16'h0;
			wPtr_r <= {(BUF_AW+1){1'b0}};
			rPtr_r <= {BUF_AW{1'b0}};
			dOff_r <= 16'h0;
			buf0Stat_r <= `THL_BS_LOCKED;
			buf1Stat_r <= `THL_BS_LOCKED;
			tagStat_r <= 8'h00;
			pdo2Cap_r <= 64'h0;
			tagReq_r <= 1'b0;
			tagWe_r <= 1'b0;
			tagAddr_r <= 18'h0;
			tagWdata_r <= 8'h00;
		end else begin
			if (regWr & (regAddr == `THL_AUTO_MODE)) begin
				auto_r <= regWdata[7:0];
			end
			if (~tagPresent) begin
				waitGone_r <= 1'b0;
			end
			// Buffer status follows control writes
			if (regWr & (regAddr == `THL_BUF0_CTRL)) begin
				buf0Stat_r <= (regWdata[7:0] == `THL_BC_LOCK) ? `THL_BS_LOCKED : `THL_BS_READY;
			end
			if (regWr & (regAddr == `THL_BUF1_CTRL)) begin
				buf1Stat_r <= (regWdata[7:0] == `THL_BC_LOCK) ? `THL_BS_LOCKED : `THL_BS_READY;
				dOff_r <= 16'h0;
			end
			// Buffer 0 read pointer walks with data reads, a write rewinds it
			if (rdB0Data) begin
				rPtr_r <= rPtr_r + 1'b1;
			end
			if (wrB0Data) begin
				rPtr_r <= {BUF_AW{1'b0}};
			end
			if (wrCmd) begin
				tagReq_r <= 1'b0;
				if (state_r == ST_ERR) begin
					if (cmd == `THL_CMD_DISCONNECT) begin
						state_r <= ST_IDLE;
					end
				end else begin
					case (cmd)
						`THL_CMD_CONNECT: begin
							state_r <= ST_CONN;
							waitGone_r <= 1'b0;
						end
						`THL_CMD_DISCONNECT: begin
							state_r <= ST_IDLE;
						end
						`THL_CMD_RECONNECT: begin
							state_r <= ST_CONN;
							waitGone_r <= 1'b1;
						end
						`THL_CMD_ERROR: begin
							state_r <= ST_ERR;
						end
						default: begin
							state_r <= state_r;
						end
					endcase
				end
			end else begin
				case (state_r)
					ST_CONN: begin
						if (tagArrive) begin
							tagStat_r <= tagStatus;
							if (doFetch) begin
								state_r <= ST_FETCH;
								fIdx_r <= 1'b0;
								fOff_r <= 16'h0;
								wPtr_r <= {(BUF_AW+1){1'b0}};
								rPtr_r <= {BUF_AW{1'b0}};
								pdo2Cap_r <= 64'h0;
								buf0Stat_r <= `THL_BS_BUSY;
							end else begin
								state_r <= ST_LINKED;
								pdo2Cap_r <= {56'h0, tagStatus};
							end
						end
					end
					ST_FETCH: begin
						if (curEmpty) begin
							fOff_r <= 16'h0;
							fIdx_r <= 1'b1;
							if (fIdx_r) begin
								state_r <= ST_DONE;
								buf0Stat_r <= `THL_BS_DONE;
							end
						end else if (curIsStat) begin
							fOff_r <= fOff_r + 16'h1;
						end else if (~tagReq_r) begin
							tagReq_r <= 1'b1;
							tagWe_r <= 1'b0;
							tagAddr_r <= fetchAddr;
						end else if (tagAck) begin
							tagReq_r <= 1'b0;
							fOff_r <= fOff_r + 16'h1;
						end
						if (gotByte) begin
							if (~wPtr_r[BUF_AW]) begin
								wPtr_r <= wPtr_r + 1'b1;
							end
							if (wPtr_r < 8) begin
								pdo2Cap_r[{wPtr_r[2:0], 3'b000} +: 8] <= gotData;
							end
						end
					end
					ST_DONE: begin
						if (auto_r == `THL_AUTO_RECONNECT) begin
							state_r <= ST_CONN;
							waitGone_r <= 1'b1;
						end else if (auto_r == `THL_AUTO_DISCONNECT) begin
							state_r <= ST_IDLE;
						end else begin
							state_r <= ST_LINKED;
						end
					end
					ST_LINKED: begin
						if (dirGo) begin
							tagReq_r <= 1'b1;
							tagWe_r <= 1'b1;
							tagAddr_r <= {b1Ent[31:16], 2'b00} + {2'b00, dOff_r};
							tagWdata_r <= regWdata[7:0];
							buf1Stat_r <= `THL_BS_BUSY;
						end else if (tagReq_r & tagAck) begin
							tagReq_r <= 1'b0;
							dOff_r <= dOff_r + 16'h1;
							if (dOff_r + 16'h1 == b1Ent[15:0]) begin
								buf1Stat_r <= `THL_BS_DONE;
							end
						end
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// PDO event queue: a new event wins over the send that clears it
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pend_r <= 3'h0;
			prevState_r <= ST_IDLE;
			sentCode_r <= `THL_LS_IDLE;
			prevStat_r <= 16'h0;
			pdoValid_r <= 1'b0;
			pdoNum_r <= 3'h0;
			pdoData_r <= 64'h0;
			tp4Cnt_r <= 8'h00;
			tp4E1_r <= 32'h0;
			tp4E2_r <= 32'h0;
		end else begin
			prevState_r <= state_r;
			// Code of the state one cycle ago, so a one-cycle state is still reported
			sentCode_r <= linkCode;
			prevStat_r <= {buf1Stat_r, buf0Stat_r};
			pend_r <= setPend | (pend_r & ~sentPend);
			pdoValid_r <= |pend_r;
			if (pend_r[0]) begin
				pdoNum_r <= `THL_PDO1;
				pdoData_r <= {61'h0, sentCode_r};
			end else if (pend_r[1]) begin
				pdoNum_r <= `THL_PDO2;
				pdoData_r <= pdo2Cap_r;
			end else if (pend_r[2]) begin
				pdoNum_r <= `THL_PDO4;
				pdoData_r <= {48'h0, buf1Stat_r, buf0Stat_r};
			end
			if (regWr & (regAddr == `THL_TP4_BASE)) begin
				tp4Cnt_r <= regWdata[7:0];
			end
			if (regWr & (regAddr == `THL_TP4_BASE + `THL_SUB1)) begin
				tp4E1_r <= regWdata;
			end
			if (regWr & (regAddr == `THL_TP4_BASE + `THL_SUB2)) begin
				tp4E2_r <= regWdata;
			end
		end
	end

	// Link state code seen by software and PDO 1
	always @* begin
		case (state_r)
			ST_IDLE: linkCode = `THL_LS_IDLE;
			ST_CONN: linkCode = `THL_LS_CONNECTING;
			ST_FETCH: linkCode = `THL_LS_FETCHING;
			ST_DONE: linkCode = `THL_LS_PREFETCH_DONE;
			ST_LINKED: linkCode = `THL_LS_CONNECTED;
			ST_ERR: linkCode = `THL_LS_ERROR;
			default: linkCode = `THL_LS_ERROR;
		endcase
	end

	// ==========================================================
	// Read mux, unmapped addresses read zero
	always @* begin
		case (regAddr)
			`THL_ACT_STATE: rdMux = {29'h0, linkCode};
			`THL_AUTO_MODE: rdMux = {24'h0, auto_r};
			`THL_TAG_STAT: rdMux = {24'h0, tagStat_r};
			`THL_BUF0_CTRL: rdMux = {24'h0, ctrlW[7:0]};
			`THL_BUF1_CTRL: rdMux = {24'h0, ctrlW[15:8]};
			`THL_BUF0_STAT: rdMux = {24'h0, buf0Stat_r};
			`THL_BUF1_STAT: rdMux = {24'h0, buf1Stat_r};
			`THL_MAP0_BASE: rdMux = {24'h0, cntW[7:0]};
			`THL_MAP0_BASE + `THL_SUB1: rdMux = prep1W[31:0];
			`THL_MAP0_BASE + `THL_SUB2: rdMux = prep2W[31:0];
			`THL_MAP1_BASE: rdMux = {24'h0, cntW[15:8]};
			`THL_MAP1_BASE + `THL_SUB1: rdMux = prep1W[63:32];
			`THL_MAP1_BASE + `THL_SUB2: rdMux = prep2W[63:32];
			`THL_TP4_BASE: rdMux = {24'h0, tp4Cnt_r};
			`THL_TP4_BASE + `THL_SUB1: rdMux = tp4E1_r;
			`THL_TP4_BASE + `THL_SUB2: rdMux = tp4E2_r;
			default: rdMux = 32'h0;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 32'h0;
			rdMem_r <= 1'b0;
		end else begin
			rdata_r <= (regRd & ~rdB0Data) ? rdMux : 32'h0;
			rdMem_r <= rdB0Data;
		end
	end

	assign regRdata = rdMem_r ? {24'h0, memQ} : rdata_r;

endmodule

// file: verif/thl_lc_checker.sv
// Port checker of the link command block
`timescale 1ns/10ps
`include "thl_consts.vh"
module thl_lc_checker #(
	parameter BUF_AW = 6
) (
	input wire mclk, // Clock
	input wire rst_b, // Reset
	input wire [7:0] regAddr, // Address
	input wire [31:0] regWdata, // Wr data
	input wire regWr, // Wr strobe
	input wire regRd, // Rd strobe
	input wire [31:0] regRdata, // Rd data
	input wire tagPresent, // Tag here
	input wire [7:0] tagStatus, // Tag status
	input wire tagReq_r, // Tag request
	input wire tagWe_r, // Tag write
	input wire [17:0] tagAddr_r, // Tag addr
	input wire [7:0] tagWdata_r, // Tag byte
	input wire tagAck, // Tag done
	input wire [7:0] tagRdata, // Tag rd byte
	input wire pdoValid_r, // PDO pulse
	input wire [2:0] pdoNum_r, // PDO number
	input wire [63:0] pdoData_r // PDO payload
);
	wire cmdWr;
	// Command writes may drop a pending tag access
	assign cmdWr = regWr && regAddr == `THL_CMD_STATE;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Register port and tag link
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside its slot");
	a_req_held: assert property (tagReq_r && !tagAck && !cmdWr
		|=> tagReq_r && $stable({tagAddr_r, tagWe_r, tagWdata_r}))
		else $error("tag request changed before ack");
	a_req_drop: assert property (tagReq_r && tagAck |=> !tagReq_r)
		else $error("tag request held after ack");
	a_wbyte_src: assert property ($rose(tagReq_r) && tagWe_r
		|-> $past(regWr) && $past(regAddr) == `THL_BUF1_DATA
		&& tagWdata_r == $past(regWdata[7:0]))
		else $error("tag write not from buffer 1 write");
	// ==========================================================
	// Process data
	a_pdo_num: assert property (pdoValid_r |-> pdoNum_r inside {3'h1, 3'h2, 3'h4})
		else $error("bad PDO number");
	a_pdo1_code: assert property (pdoValid_r && pdoNum_r == `THL_PDO1
		|-> pdoData_r <= 64'h5)
		else $error("bad link code in PDO1");
	a_pdo4_form: assert property (pdoValid_r && pdoNum_r == `THL_PDO4
		|-> pdoData_r[63:16] == 48'h0 && pdoData_r[15:8] <= 8'h3 && pdoData_r[7:0] <= 8'h3)
		else $error("bad PDO4 payload");
	a_err_pdo: assert property (cmdWr && regWdata[7:0] == `THL_CMD_ERROR
		|-> ##[1:3] pdoValid_r && pdoNum_r == `THL_PDO1 && pdoData_r[2:0] == `THL_LS_ERROR)
		else $error("no error state after error command");
	// Main scenarios reached
	c_pdo4: cover property (pdoValid_r && pdoNum_r == `THL_PDO4);
	c_pdo2: cover property (pdoValid_r && pdoNum_r == `THL_PDO2);
	c_twrite: cover property (tagAck && tagWe_r);
endmodule
bind thl_link_cmd thl_lc_checker #(.BUF_AW(BUF_AW)) uChk (.mclk(mclk), .rst_b(rst_b),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .tagPresent(tagPresent), .tagStatus(tagStatus),
	.tagReq_r(tagReq_r), .tagWe_r(tagWe_r), .tagAddr_r(tagAddr_r), .tagWdata_r(tagWdata_r),
	.tagAck(tagAck), .tagRdata(tagRdata), .pdoValid_r(pdoValid_r), .pdoNum_r(pdoNum_r),
	.pdoData_r(pdoData_r));

// file: verif/thl_tag_model.sv
// Behavioural mobile_tag answering byte accesses of the head
`timescale 1ns/10ps
module thl_tag_model (
	input wire mclk, // Clock
	input wire rst_b, // Reset
	input wire slow, // Four-cycle accesses
	input wire tagReq_r, // Request
	input wire tagWe_r, // Write access
	input wire [17:0] tagAddr_r, // Byte address
	input wire [7:0] tagWdata_r, // Write byte
	output reg tagAck, // Done pulse
	output reg [7:0] tagRdata // Read byte
);
	reg [7:0] mem_r [0:1023];
	reg [2:0] waitCnt_r;
	integer i;
	// Memory starts with a known pattern
	initial begin
		for (i = 0; i < 1024; i = i + 1) mem_r[i] = i[7:0] ^ 8'hA5;
	end
	// Answer after a short or long wait; read byte is scrambled outside the ack
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			waitCnt_r <= 3'h0;
			tagAck <= 1'b0;
			tagRdata <= 8'h00;
		end else begin
			tagAck <= 1'b0;
			tagRdata <= ~tagRdata;
			if (tagReq_r && !tagAck) begin
				waitCnt_r <= waitCnt_r + 3'h1;
				if (waitCnt_r == (slow ? 3'h3 : 3'h0)) begin
					waitCnt_r <= 3'h0;
					tagAck <= 1'b1;
					tagRdata <= mem_r[tagAddr_r[9:0]];
					if (tagWe_r) mem_r[tagAddr_r[9:0]] <= tagWdata_r;
				end
			end
		end
	end
endmodule

// file: verif/thl_link_cmd_test.sv
// Self-checking bench of the link command block with a tag model
`timescale 1ns/10ps
module thl_link_cmd_test;
	reg mclk;
	reg rst_b;
	reg [7:0] regAddr;
	reg [31:0] regWdata;
	reg regWr;
	reg regRd;
	reg tagPresent;
	reg [7:0] tagStatus;
	reg slow;
	reg [8:0] hist;
	reg [63:0] lastP2;
	reg [15:0] lastP4;
	reg [31:0] rv;
	wire [31:0] regRdata;
	wire tagReq_r, tagWe_r, tagAck, pdoValid_r;
	wire [17:0] tagAddr_r;
	wire [7:0] tagWdata_r, tagRdata;
	wire [2:0] pdoNum_r;
	wire [63:0] pdoData_r;
	integer numErrors, totalChecks, cycles, pdo2Cnt, n0;
	// ==========================================================
	// Design and tag model
	thl_link_cmd DUT (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .tagPresent(tagPresent),
		.tagStatus(tagStatus), .tagReq_r(tagReq_r), .tagWe_r(tagWe_r),
		.tagAddr_r(tagAddr_r), .tagWdata_r(tagWdata_r), .tagAck(tagAck),
		.tagRdata(tagRdata), .pdoValid_r(pdoValid_r), .pdoNum_r(pdoNum_r),
		.pdoData_r(pdoData_r));
	thl_tag_model uTag (.mclk(mclk), .rst_b(rst_b), .slow(slow), .tagReq_r(tagReq_r),
		.tagWe_r(tagWe_r), .tagAddr_r(tagAddr_r), .tagWdata_r(tagWdata_r), .tagAck(tagAck),
		.tagRdata(tagRdata));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Record PDOs in mid-cycle
	always @(negedge mclk) begin
		if (pdoValid_r === 1'b1 && pdoNum_r === 3'h1) hist <= {hist[5:0], pdoData_r[2:0]};
		if (pdoValid_r === 1'b1 && pdoNum_r === 3'h2) begin
			pdo2Cnt <= pdo2Cnt + 1;
			lastP2 <= pdoData_r;
		end
		if (pdoValid_r === 1'b1 && pdoNum_r === 3'h4) lastP4 <= pdoData_r[15:0];
	end
	// Cut a hang short
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			numErrors = numErrors + 1;
			wrap_up;
		end
	end
	// ==========================================================
	// Helpers
	task chk(input [31:0] got, input [31:0] exp);
		begin
			totalChecks = totalChecks + 1;
			if (got !== exp) begin
				numErrors = numErrors + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'b1;
			@(posedge mclk);
			regWr <= 1'b0;
			@(posedge mclk);
		end
	endtask
	task rd(input [7:0] a, output [31:0] v);
		begin
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge mclk);
			regRd <= 1'b0;
			#1 v = regRdata;
			@(posedge mclk);
		end
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			rd(a, rv);
			chk(rv, e);
		end
	endtask
	task ws(input [2:0] code);
		integer i;
		begin
			rv = 32'hFFFFFFFF;
			for (i = 0; i < 100 && rv !== {29'h0, code}; i = i + 1) rd(8'h00, rv);
			chk(rv, {29'h0, code});
		end
	endtask
	task tagCycle;
		begin
			tagPresent <= 1'b0;
			repeat (3) @(posedge mclk);
			tagPresent <= 1'b1;
			@(posedge mclk);
		end
	endtask
	task waitHist(input [8:0] pat);
		integer i;
		begin
			for (i = 0; i < 80 && hist !== pat; i = i + 1) @(posedge mclk);
		end
	endtask
	task waitIdle;
		integer i;
		begin
			for (i = 0; i < 40 && tagReq_r !== 1'b0; i = i + 1) @(negedge mclk);
			@(posedge mclk);
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", totalChecks, numErrors);
			if (numErrors == 0 && totalChecks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		begin
			rc(8'h00, 32'h0);
			rc(8'h08, 32'h0);
			rc(8'h10, 32'h0);
			rc(8'h04, 32'h0);
			rc(8'hFC, 32'h0);
		end
	endtask
	task t_setup;
		begin
			wr(8'h10, 32'h0);
			wr(8'h14, 32'h0);
			rc(8'h18, 32'h0);
			wr(8'h44, 32'h12345678);
			wr(8'h40, 32'h0);
			rc(8'h44, 32'h0);
			wr(8'h44, 32'h80000001);
			wr(8'h48, 32'h00440004);
			wr(8'h40, 32'h2);
			rc(8'h48, 32'h00440004);
			wr(8'h54, 32'h00400002);
			wr(8'h50, 32'h1);
			wr(8'h14, 32'h1);
			rc(8'h1C, 32'h1);
			wr(8'h10, 32'h3);
			wr(8'h40, 32'h0);
			rc(8'h40, 32'h2);
			wr(8'h64, 32'h21000208);
			wr(8'h68, 32'h21010208);
			wr(8'h60, 32'h2);
		end
	endtask
	task t_fetch;
		begin
			tagStatus <= 8'h3C;
			wr(8'h04, 32'h1);
			rc(8'h00, 32'h1);
			tagPresent <= 1'b1;
			ws(3'h4);
			rc(8'h0C, 32'h3C);
			rc(8'h18, 32'h3);
			chk({16'h0, lastP4}, 32'h0103);
			chk(lastP2[31:0], 32'hB7B4B53C);
			wr(8'h20, 32'h0);
			rc(8'h20, 32'h3C);
			rc(8'h20, 32'hB5);
			rc(8'h20, 32'hB4);
			rc(8'h20, 32'hB7);
			rc(8'h20, 32'hB6);
		end
	endtask
	task t_direct;
		begin
			slow <= 1'b1;
			wr(8'h24, 32'h11);
			waitIdle;
			wr(8'h24, 32'h22);
			waitIdle;
			chk({24'h0, uTag.mem_r[256]}, 32'h11);
			chk({24'h0, uTag.mem_r[257]}, 32'h22);
			rc(8'h1C, 32'h3);
			slow <= 1'b0;
		end
	endtask
	task t_auto;
		begin
			wr(8'h08, 32'h1);
			rc(8'h08, 32'h1);
			wr(8'h04, 32'h3);
			rc(8'h00, 32'h1);
			n0 = pdo2Cnt;
			tagCycle;
			waitHist(9'h099);
			chk({23'h0, hist}, 32'h099);
			chk(pdo2Cnt - n0, 32'h1);
		end
	endtask
	task t_autodis;
		begin
			wr(8'h08, 32'h2);
			rc(8'h08, 32'h2);
			tagCycle;
			waitHist(9'h098);
			chk({23'h0, hist}, 32'h098);
			rc(8'h00, 32'h0);
			tagPresent <= 1'b0;
			wr(8'h04, 32'h1);
			rc(8'h00, 32'h1);
		end
	endtask
	task t_error;
		begin
			wr(8'h04, 32'h4);
			ws(3'h5);
			wr(8'h04, 32'h2);
			ws(3'h0);
		end
	endtask
	// Reset, then run every scenario
	initial begin
		rst_b = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		tagPresent = 1'b0;
		tagStatus = 8'h00;
		slow = 1'b0;
		hist = 9'h000;
		numErrors = 0;
		totalChecks = 0;
		cycles = 0;
		pdo2Cnt = 0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		t_reset;
		t_setup;
		t_fetch;
		t_direct;
		t_auto;
		t_autodis;
		t_error;
		wrap_up;
	end
endmodule
